// file: rtl/jtp_pkg.sv
// Package for the test and debug port: instruction codes, field layouts, types
package jtp_pkg;
	localparam int IR_W   = 4;
	localparam int DR_W   = 32;
	localparam int SEC_W  = 32;

	// Instruction codes; bypass is all ones as usual
	localparam logic [3:0] INS_EXTEST   = 4'h0;
	localparam logic [3:0] INS_SAMPLE   = 4'h1;
	localparam logic [3:0] INS_DEVICE_IDENTIFICATION   = 4'h2;
	localparam logic [3:0] INS_USERCODE = 4'h3;
	localparam logic [3:0] INS_CHIPTAP  = 4'h4;
	localparam logic [3:0] INS_BYPASS   = 4'hf;
	localparam logic [3:0] IR_CAPTURE   = 4'h1;

	// Identification word fields; values arbitrary and neutral
	localparam logic [3:0]  ID_VERSION  = 4'h0;
	localparam logic [15:0] ID_PART     = 16'h0001;
	localparam logic [10:0] ID_MAKER    = 11'h001;

	// User code layout: owner tag [31:22], unused [21:16], revision [15:0]
	localparam int UC_TAG_LSB  = 22;
	localparam int UC_TAG_W    = 10;
	localparam int UC_REV_W    = 16;
	localparam int UC_GAP_W    = 6;
	localparam logic [15:0] DIE_REV = 16'h0001;
	localparam int SEC_JTAG_OFF = 0;

	// Power-up low time on the test reset pin, kept by the host
	localparam int TRST_MIN_NS = 100;
	localparam int CLK_NS      = 10;
	localparam int TRST_MIN_CYC = (TRST_MIN_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} jtp_state_e;

	// Debug pin configuration from the tile software
	typedef struct packed {
		logic enable;
		logic as_output;
	} jtp_dbg_cfg_s;
endpackage

// file: rtl/jtp_tap.sv
// Test access port with nested chip port and debug synchronisation pin
// Function
// - One standard test access port heads the chain, covering boundary scan of pins; EXTEST and SAMPLE capture only zeros, no pin cells.
// - Instruction register is four bits; data register is thirty-two bits.
// - A chip-level port is reachable through the top port for code and debug.
// - Test reset low keeps the whole port in reset.
// - Debug pin as output floats until breakpoint, then is driven low.
// - Debug pin as input: external low forces the tile into debug mode.
// - Debug pin direction and enable are set by software configuration.
// - Identification word: version, part, maker, least bit one.
// - User code: owner tag from security bits 31..22, unused field, die revision.
// - Unprogrammed fuses give an all-zero owner tag.
// - Security bit 0 set disables the whole test port.
// - Security bits 31..22 are user programmable and feed the owner tag.
`timescale 1ns/1ps
module jtp_tap (
	input  wire logic                  clk_sys_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  tck_i,
	input  wire logic                  tms_i,
	input  wire logic                  tdi_i,
	input  wire logic                  trst_n_i,
	output logic                       tdo_o,
	output logic                       tdo_oe_o,
	input  wire logic [31:0]           security_i,
	input  wire jtp_pkg::jtp_dbg_cfg_s dbg_cfg_i,
	input  wire logic                  breakpoint_i,
	input  wire logic                  debug_n_i,
	output logic                       debug_n_o,
	output logic                       debug_n_oe_o,
	output logic                       debug_req_o,
	input  wire logic                  chip_tdo_i,
	output logic                       chip_tck_o,
	output logic                       chip_tms_o,
	output logic                       chip_tdi_o
);
	logic [2:0]               tck_sync_q;
	logic [1:0]               tms_sync_q, tdi_sync_q, trst_sync_q, dbg_sync_q, chip_sync_q;
	jtp_pkg::jtp_state_e      state_q;
	logic [3:0]               ir_q, ir_sh_q;
	logic [31:0]              dr_q;
	logic                     bypass_q;
	logic                     port_rst;
	logic                     rise, fall;
	logic                     shift_st;
	logic [31:0]              id_word, uc_word;

	// Two-stage synchronisers; the edge finder uses stages two and three
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tck_sync_q  <= 3'h0;
			tms_sync_q  <= 2'h3;
			tdi_sync_q  <= 2'h3;
			trst_sync_q <= 2'h0;
			dbg_sync_q  <= 2'h3;
			chip_sync_q <= 2'h0;
		end else begin
			tck_sync_q  <= {tck_sync_q[1:0], tck_i};
			tms_sync_q  <= {tms_sync_q[0], tms_i};
			tdi_sync_q  <= {tdi_sync_q[0], tdi_i};
			trst_sync_q <= {trst_sync_q[0], trst_n_i};
			dbg_sync_q  <= {dbg_sync_q[0], debug_n_i};
			chip_sync_q <= {chip_sync_q[0], chip_tdo_i};
		end
	end

	assign rise = tck_sync_q[1] & ~tck_sync_q[2];
	assign fall = ~tck_sync_q[1] & tck_sync_q[2];
	assign port_rst = ~trst_sync_q[1] | security_i[jtp_pkg::SEC_JTAG_OFF];
	// Shift states are the only ones in which the data pin is driven
	assign shift_st = (state_q == jtp_pkg::ST_SH_DR) || (state_q == jtp_pkg::ST_SH_IR);

	assign id_word = {jtp_pkg::ID_VERSION, jtp_pkg::ID_PART, jtp_pkg::ID_MAKER, 1'b1};
	// Unprogrammed fuses read zero, so the tag is zero too
	assign uc_word = {security_i[31:jtp_pkg::UC_TAG_LSB], {jtp_pkg::UC_GAP_W{1'b0}}, jtp_pkg::DIE_REV};

	function automatic jtp_pkg::jtp_state_e next_state(input jtp_pkg::jtp_state_e s, input logic m);
		case (s)
			jtp_pkg::ST_RESET:  next_state = m ? jtp_pkg::ST_RESET  : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_IDLE:   next_state = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_DR: next_state = m ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
			jtp_pkg::ST_CAP_DR: next_state = m ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_SH_DR:  next_state = m ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_EX1_DR: next_state = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_PAU_DR: next_state = m ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PAU_DR;
			jtp_pkg::ST_EX2_DR: next_state = m ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
			jtp_pkg::ST_UPD_DR: next_state = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			jtp_pkg::ST_SEL_IR: next_state = m ? jtp_pkg::ST_RESET  : jtp_pkg::ST_CAP_IR;
			jtp_pkg::ST_CAP_IR: next_state = m ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_SH_IR:  next_state = m ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_EX1_IR: next_state = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_PAU_IR: next_state = m ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PAU_IR;
			jtp_pkg::ST_EX2_IR: next_state = m ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
			jtp_pkg::ST_UPD_IR: next_state = m ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_IDLE;
			default:            next_state = jtp_pkg::ST_RESET;
		endcase
	endfunction

	// Controller
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= jtp_pkg::ST_RESET;
		end else if (port_rst) begin
			state_q <= jtp_pkg::ST_RESET;
		end else if (rise) begin
			state_q <= next_state(state_q, tms_sync_q[1]);
		end
	end

	// Instruction register: reset selects the identification code
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ir_q    <= jtp_pkg::INS_DEVICE_IDENTIFICATION;
			ir_sh_q <= 4'h0;
		end else if (port_rst || (rise && state_q == jtp_pkg::ST_RESET)) begin
			ir_q    <= jtp_pkg::INS_DEVICE_IDENTIFICATION;
			ir_sh_q <= 4'h0;
		end else if (rise) begin
			case (state_q)
				jtp_pkg::ST_CAP_IR: ir_sh_q <= jtp_pkg::IR_CAPTURE;
				jtp_pkg::ST_SH_IR:  ir_sh_q <= {tdi_sync_q[1], ir_sh_q[3:1]};
				jtp_pkg::ST_UPD_IR: ir_q <= ir_sh_q;
				default: ;
			endcase
		end
	end

	// Data path: 32-bit shifter, bypass bit, boundary cells sampled as zero
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dr_q     <= 32'h0;
			bypass_q <= 1'b0;
		end else if (port_rst) begin
			dr_q     <= 32'h0;
			bypass_q <= 1'b0;
		end else if (rise) begin
			if (state_q == jtp_pkg::ST_CAP_DR) begin
				bypass_q <= 1'b0;
				case (ir_q)
					jtp_pkg::INS_DEVICE_IDENTIFICATION:   dr_q <= id_word;
					jtp_pkg::INS_USERCODE: dr_q <= uc_word;
					default:               dr_q <= 32'h0;
				endcase
			end else if (state_q == jtp_pkg::ST_SH_DR) begin
				bypass_q <= tdi_sync_q[1];
				dr_q     <= {tdi_sync_q[1], dr_q[31:1]};
			end
		end
	end

	// Drive enable follows the shift states, updated on the falling test clock
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tdo_oe_o <= 1'b0;
		end else if (port_rst) begin
			tdo_oe_o <= 1'b0;
		end else if (fall) begin
			tdo_oe_o <= shift_st;
		end
	end

	// Data out changes on the falling test clock and rests low while undriven
	// Chip port data is relayed only while the outer port shifts its data path
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tdo_o <= 1'b0;
		end else if (port_rst) begin
			tdo_o <= 1'b0;
		end else if (fall) begin
			if (!shift_st)
				tdo_o <= 1'b0;
			else if (state_q == jtp_pkg::ST_SH_IR)
				tdo_o <= ir_sh_q[0];
			else if (ir_q == jtp_pkg::INS_CHIPTAP)
				tdo_o <= chip_sync_q[1];
			else if (ir_q == jtp_pkg::INS_BYPASS)
				tdo_o <= bypass_q;
			else
				tdo_o <= dr_q[0];
		end
	end

	// Chip-level port pass-through, parked idle when not selected
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			chip_tck_o <= 1'b0;
			chip_tms_o <= 1'b1;
			chip_tdi_o <= 1'b1;
		end else if (!port_rst && ir_q == jtp_pkg::INS_CHIPTAP) begin
			chip_tck_o <= tck_sync_q[1];
			chip_tms_o <= (state_q == jtp_pkg::ST_SH_DR) ? tms_sync_q[1] : 1'b0;
			chip_tdi_o <= tdi_sync_q[1];
		end else begin
			chip_tck_o <= 1'b0;
			chip_tms_o <= 1'b1;
			chip_tdi_o <= 1'b1;
		end
	end

	// Debug synchronisation pin: open drain, low only at breakpoint
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			debug_n_o    <= 1'b1;
			debug_n_oe_o <= 1'b0;
		end else begin
			debug_n_o    <= 1'b0;
			debug_n_oe_o <= dbg_cfg_i.enable && dbg_cfg_i.as_output && breakpoint_i;
		end
	end

	// Debug request from a low level on the synchronised pin
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			debug_req_o <= 1'b0;
		end else begin
			debug_req_o <= dbg_cfg_i.enable && !dbg_cfg_i.as_output && !dbg_sync_q[1];
		end
	end
endmodule

// file: testbench/jtp_tap_props.sv
// Checker for the test port: scan-out and debug pin relations
`timescale 1ns/1ps
module jtp_tap_props (
	input wire logic                  clk_sys_i,
	input wire logic                  sys_rst_i,
	input wire logic                  tck_i,
	input wire logic                  trst_n_i,
	input wire logic                  tdo_o,
	input wire logic                  tdo_oe_o,
	input wire logic [31:0]           security_i,
	input wire jtp_pkg::jtp_dbg_cfg_s dbg_cfg_i,
	input wire logic                  breakpoint_i,
	input wire logic                  debug_n_i,
	input wire logic                  debug_n_o,
	input wire logic                  debug_n_oe_o,
	input wire logic                  debug_req_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	sequence pin_low_s;
		(dbg_cfg_i.enable && !dbg_cfg_i.as_output && !debug_n_i) [*4];
	endsequence
	sequence bp_out_s;
		(dbg_cfg_i.enable && dbg_cfg_i.as_output && breakpoint_i) [*2];
	endsequence
	dbg_float_a: assert property (debug_n_oe_o |-> dbg_cfg_i.enable && dbg_cfg_i.as_output)
		else $error("debug pin driven while not an enabled output");
	bp_drive_a: assert property (bp_out_s |-> debug_n_oe_o && !debug_n_o)
		else $error("debug pin not driven low at breakpoint");
	req_force_a: assert property (pin_low_s |-> ##[0:2] debug_req_o)
		else $error("low debug pin did not force debug mode");
	req_cfg_a: assert property (debug_req_o |-> dbg_cfg_i.enable && !dbg_cfg_i.as_output)
		else $error("debug request outside input configuration");
	trst_hold_a: assert property ((!trst_n_i) [*4] |-> !tdo_oe_o && !tdo_o)
		else $error("port active while test reset low");
	sec_off_a: assert property (security_i[0] [*4] |-> !tdo_oe_o)
		else $error("port active while disabled by security");
	tdo_quiet_a: assert property (!tdo_oe_o |-> !tdo_o)
		else $error("data out not low while undriven");
	tdo_fall_a: assert property ($changed(tdo_o) |-> !tck_i)
		else $error("data out changed while test clock high");
endmodule
bind jtp_tap jtp_tap_props u_props (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i),
	.trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .security_i(security_i), .dbg_cfg_i(dbg_cfg_i),
	.breakpoint_i(breakpoint_i), .debug_n_i(debug_n_i), .debug_n_o(debug_n_o), .debug_n_oe_o(debug_n_oe_o),
	.debug_req_o(debug_req_o));

// file: testbench/jtp_host.sv
// Host model: test clock, mode select, data in and test reset
`timescale 1ns/1ps
module jtp_host (
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	output logic      trst_n_o,
	input  wire logic tdo_i
);
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
		trst_n_o = 1'b0;
	end
	// One test clock; the clock idles low between frames
	task automatic step(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#80 tck_o = 1'b1;
		q = tdo_i;
		#80 tck_o = 1'b0;
	endtask
	task automatic hold_reset();
		trst_n_o = 1'b0;
		#200 trst_n_o = 1'b1;
	endtask
	// From idle: header to shift state, n bits, then back to idle
	task automatic scan(input logic [3:0] hdr, input logic [31:0] din, input int n, output logic [31:0] dout);
		logic q;
		dout = '0;
		for (int i = 0; i < 4; i++)
			step(hdr[i], 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~din[n-1], q);
		step(1'b0, din[n-1], q);
	endtask
endmodule

// file: testbench/tb_jtp_tap.sv
// Testbench for the test and debug port
`timescale 1ns/1ps
module tb_jtp_tap;
	logic                  clk, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, bp, dbg_in_n, dbg_o, dbg_oe, req;
	logic                  chip_tdo, chip_tck, chip_tms, chip_tdi;
	logic [31:0]           sec, got;
	jtp_pkg::jtp_dbg_cfg_s cfg;
	int                    miscompares, check_count, ticks;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Data out pin is pulled high when not driven
	jtp_host u_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .tdo_i(tdo_oe ? tdo : 1'b1));
	jtp_tap u_dut (.clk_sys_i(clk), .sys_rst_i(rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .security_i(sec), .dbg_cfg_i(cfg), .breakpoint_i(bp),
		.debug_n_i(dbg_in_n), .debug_n_o(dbg_o), .debug_n_oe_o(dbg_oe), .debug_req_o(req),
		.chip_tdo_i(chip_tdo), .chip_tck_o(chip_tck), .chip_tms_o(chip_tms), .chip_tdi_o(chip_tdi));
	always @(posedge chip_tck) ticks++;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic t_codes();
		u_host.scan(4'b0010, 32'h0, 32, got);
		chk(got, {jtp_pkg::ID_VERSION, jtp_pkg::ID_PART, jtp_pkg::ID_MAKER, 1'b1});
		for (int i = 0; i < 2; i++) begin
			sec = i ? 32'hb680_0000 : 32'h0;
			u_host.scan(4'b0011, {28'h0, jtp_pkg::INS_USERCODE}, 4, got);
			chk(got, {28'h0, jtp_pkg::IR_CAPTURE});
			u_host.scan(4'b0010, 32'h0, 32, got);
			chk(got, {sec[31:22], 6'h0, jtp_pkg::DIE_REV});
		end
		u_host.hold_reset();
		u_host.scan(4'b0010, 32'h0, 32, got);
		chk(got, {jtp_pkg::ID_VERSION, jtp_pkg::ID_PART, jtp_pkg::ID_MAKER, 1'b1});
		$display("codes test done");
	endtask
	task automatic t_access();
		sec = 32'h1;
		u_host.scan(4'b0010, 32'h0, 32, got);
		chk(got, 32'hffff_ffff);
		sec = 32'h0;
		u_host.step(1'b0, 1'b0, got[0]);
		chk({chip_tms, chip_tdi}, 2'b11);
		u_host.scan(4'b0011, {28'h0, jtp_pkg::INS_CHIPTAP}, 4, got);
		chk(got, {28'h0, jtp_pkg::IR_CAPTURE});
		chip_tdo = 1'b1;
		ticks = 0;
		u_host.scan(4'b0010, 32'h0, 32, got);
		chk(got, 32'hffff_ffff);
		chk(ticks, 38);
		chk({chip_tms, chip_tdi}, 2'b00);
		chip_tdo = 1'b0;
		u_host.scan(4'b0011, {28'h0, jtp_pkg::INS_BYPASS}, 4, got);
		chk(got, {28'h0, jtp_pkg::IR_CAPTURE});
		u_host.scan(4'b0010, 32'ha5a5_0f0f, 32, got);
		chk(got, 32'h4b4a_1e1e);
		$display("access test done");
	endtask
	task automatic t_dbg();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) #1 cfg = i[1:0];
			bp = 1'b1;
			dbg_in_n = 1'b0;
			repeat (8) @(posedge clk);
			chk({dbg_oe, req}, {i == 3, i == 2});
			#1 bp = 1'b0;
			dbg_in_n = 1'b1;
			repeat (8) @(posedge clk);
			chk({dbg_oe, req}, 2'b00);
		end
		$display("debug pin test done");
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#500_000 miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		results();
	end
	initial begin
		{rst, bp, chip_tdo, dbg_in_n, sec, cfg} = {1'b1, 3'b001, 32'h0, 2'b00};
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		u_host.hold_reset();
		t_codes();
		t_access();
		t_dbg();
		results();
	end
endmodule
